// ===== core/abs_xfer_pkg.sv
// constants and types for the absolute position handshake block
package abs_xfer_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned OFF_MIN_MS = 20;
  localparam int unsigned SON_WAIT_MS = 1000;
  localparam int unsigned HS_TMO_MS = 5000;
  localparam longint unsigned OFF_MIN_CYC = (longint'(OFF_MIN_MS) * CLK_HZ + 64'h3e7) / 64'h3e8;
  localparam longint unsigned SON_WAIT_CYC = (longint'(SON_WAIT_MS) * CLK_HZ) / 64'h3e8;
  localparam longint unsigned HS_TMO_CYC = (longint'(HS_TMO_MS) * CLK_HZ) / 64'h3e8;
  localparam int POS_W = 32;
  localparam int CSUM_W = 6;
  localparam int GRP_W = 2;
  localparam int NGRP = (POS_W + CSUM_W) / GRP_W;
  localparam int NDATA = POS_W / GRP_W;
  localparam int CNT_W = 26;
  localparam logic [3:0] A_CFG = 4'h0;
  localparam logic [3:0] A_STAT = 4'h4;
  localparam logic [3:0] A_PCMD = 4'h8;
  localparam logic [3:0] A_HOME = 4'hc;
  localparam int CFG_OPT = 0;
  localparam int CFG_RESTART = 1;
  localparam int ST_TMO = 0;
  localparam int ST_SON = 1;
  localparam int ST_RDY = 2;
  localparam int ST_STAGE = 3;
  localparam int ST_OPT = 4;
  localparam int ST_FSM = 5;
  localparam int I_MODE = 0;
  localparam int I_REQ = 1;
  localparam int I_HOME = 2;
  localparam int I_SON = 3;
  localparam int I_FCLR = 4;
  localparam int I_FSTOP = 5;
  localparam int N_IN = 6;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_CALC = 3'b001,
    S_RDY = 3'b010,
    S_SEND = 3'b011,
    S_LAST = 3'b100
  } xfer_state_t;
endpackage

// ===== core/abs_xfer.sv
// absolute position transfer over discrete handshake pins, with avalon-mm registers
//
// The Avalon-MM slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps
module abs_xfer
  import abs_xfer_pkg::*;
#(
  parameter int unsigned OFF_CYC = 32'(OFF_MIN_CYC),
  parameter int unsigned SON_CYC = 32'(SON_WAIT_CYC),
  parameter int unsigned TMO_CYC = 32'(HS_TMO_CYC)
)(
  // clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // avalon-mm slave
  input wire logic [3:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  // handshake and command pins from the controller
  input wire logic POSITION_TRANSFER_MODE,
  input wire logic POSITION_GROUP_REQUEST,
  input wire logic HOME_SET_CMD,
  input wire logic SERVO_ENABLE_IN,
  input wire logic FAULT_CLEAR_IN,
  input wire logic FORCED_STOP_IN,
  // shared output pins
  output logic DATA_BIT_LOW,
  output logic DATA_BIT_HIGH,
  output logic DATA_VALID_STROBE,
  // servo core side
  input wire logic [POS_W-1:0] POS_NOW,
  input wire logic ALARM,
  input wire logic IN_POSITION,
  input wire logic ZERO_SPEED,
  input wire logic TORQUE_LIMIT,
  output logic STAGE_ENABLE,
  output logic READY_OUT,
  output logic [POS_W-1:0] POS_CMD,
  output logic POS_CMD_LOAD,
  output logic COUNTER_CLEAR,
  output logic HOME_STORE,
  output logic [POS_W-1:0] HOME_POS,
  output logic WARN_TIMEOUT,
  output logic WARN_SERVO_ON
);
  initial
  begin
    if (OFF_CYC < 1 || SON_CYC < 1 || TMO_CYC < 1 || TMO_CYC >= (1 << CNT_W) || SON_CYC >= (1 << CNT_W)
        || OFF_CYC >= (1 << CNT_W))
      $error("abs_xfer: cycle counts out of range");
  end

  // three-stage input filters; a level counts once stages two and three agree
  wire [N_IN-1:0] raw = {FORCED_STOP_IN, FAULT_CLEAR_IN, SERVO_ENABLE_IN, HOME_SET_CMD,
                         POSITION_GROUP_REQUEST, POSITION_TRANSFER_MODE};
  logic [N_IN-1:0] s1_q, s2_q, s3_q, f_q, fp_q;
  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++)
    begin : g_sync
      always_ff @(posedge CLK)
      begin
        if (RESET)
        begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
          f_q[gi] <= 1'b0;
          fp_q[gi] <= 1'b0;
        end
        else
        begin
          s1_q[gi] <= raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi])
            f_q[gi] <= s3_q[gi];
          fp_q[gi] <= f_q[gi];
        end
      end
    end
  endgenerate

  logic opt_cfg_q, opt_act_q;
  xfer_state_t st_q, st_d;
  logic [POS_W+CSUM_W-1:0] frame_q;
  logic [4:0] grp_q;
  logic [CNT_W-1:0] tmr_q, son_cnt_q, off_cnt_q;
  logic ready_q, entered_q, stage_q, tmo_q, sonw_q;
  logic [POS_W-1:0] pcmd_q, home_q;
  logic pload_q, cclr_q, hstore_q, b0_q, b1_q, stb_q, wait_q;
  logic [31:0] rdata_q;

  // pins only act as mode and request once the option is active
  wire mode = f_q[I_MODE] & opt_act_q;
  wire mode_rise = mode & ~(fp_q[I_MODE] & opt_act_q);
  wire req = f_q[I_REQ];
  wire servo_enable_in = f_q[I_SON];
  wire son_fall = ~servo_enable_in & fp_q[I_SON];
  wire fclr_rise = f_q[I_FCLR] & ~fp_q[I_FCLR];
  wire fstop_fall = ~f_q[I_FSTOP] & fp_q[I_FSTOP];
  wire home_rise = f_q[I_HOME] & ~fp_q[I_HOME];
  wire off_ok = off_cnt_q >= CNT_W'(OFF_CYC);
  // alarm, ready, live stage and short off time all refuse entry
  wire accept = mode_rise & ~ALARM & ~ready_q & ~stage_q & off_ok;
  wire busy = (st_q == S_CALC) || (st_q == S_RDY) || (st_q == S_SEND);
  wire abort_ev = busy & (~mode | son_fall | fclr_rise | fstop_fall);
  wire hs_tmo = (st_q != S_IDLE) && (st_q != S_CALC) && (tmr_q >= CNT_W'(TMO_CYC));
  wire last_grp = grp_q == 5'(NGRP - 1);
  wire [1:0] grp_bits = frame_q[2*grp_q +: 2];
  wire repurpose = mode;
  wire restart = WRITE & ~wait_q & (ADDRESS == A_CFG) & WRITEDATA[CFG_RESTART];

  // checksum: six-bit sum of the sixteen data pairs
  function automatic logic [CSUM_W-1:0] csum(input logic [POS_W-1:0] p);
    logic [CSUM_W-1:0] s;
    s = '0;
    for (int k = 0; k < NDATA; k++)
      s = s + CSUM_W'(p[2*k +: 2]);
    return s;
  endfunction

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      S_IDLE: if (accept) st_d = S_CALC;
      S_CALC: st_d = abort_ev ? S_IDLE : S_RDY;
      S_RDY: if (abort_ev || hs_tmo) st_d = S_IDLE; else if (req) st_d = S_SEND;
      S_SEND: if (abort_ev || hs_tmo) st_d = S_IDLE; else if (!req) st_d = last_grp ? S_LAST : S_RDY;
      S_LAST: if (!mode) st_d = S_IDLE;
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RESET || restart)
    begin
      st_q <= S_IDLE;
      grp_q <= '0;
      tmr_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      tmr_q <= (st_d != st_q) ? '0 : tmr_q + CNT_W'(!hs_tmo);
      if (st_q == S_IDLE)
        grp_q <= '0;
      else if (st_q == S_SEND && !req)
        grp_q <= grp_q + 5'h1;
    end
  end

  // position latch, command load and checksum build
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      frame_q <= '0;
      pcmd_q <= '0;
      pload_q <= 1'b0;
    end
    else
    begin
      pload_q <= accept;
      if (accept)
      begin
        frame_q <= {{CSUM_W{1'b0}}, POS_NOW};
        pcmd_q <= POS_NOW;
      end
      else if (st_q == S_CALC)
        frame_q[POS_W +: CSUM_W] <= csum(frame_q[POS_W-1:0]);
    end
  end

  // warnings, ready, power stage; set beats clear
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      tmo_q <= 1'b0;
      sonw_q <= 1'b0;
      son_cnt_q <= '0;
      ready_q <= 1'b0;
      entered_q <= 1'b0;
      stage_q <= 1'b0;
      off_cnt_q <= CNT_W'(OFF_CYC);
    end
    else
    begin
      if (abort_ev || hs_tmo)
        tmo_q <= 1'b1;
      else if (mode_rise)
        tmo_q <= 1'b0;
      son_cnt_q <= (st_q != S_IDLE && mode && !servo_enable_in) ? son_cnt_q + CNT_W'(son_cnt_q < CNT_W'(SON_CYC)) : '0;
      if (son_cnt_q >= CNT_W'(SON_CYC))
        sonw_q <= 1'b1;
      else if (servo_enable_in)
        sonw_q <= 1'b0;
      if (st_q == S_LAST && !mode)
        ready_q <= 1'b1;
      else if (!servo_enable_in)
        ready_q <= 1'b0;
      if (accept)
        entered_q <= 1'b1;
      else if (!servo_enable_in)
        entered_q <= 1'b0;
      stage_q <= servo_enable_in & entered_q & f_q[I_FSTOP] & ~ALARM;
      off_cnt_q <= stage_q ? '0 : off_cnt_q + CNT_W'(!off_ok);
    end
  end

  // home set and shared pin drive
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      cclr_q <= 1'b0;
      hstore_q <= 1'b0;
      home_q <= '0;
      b0_q <= 1'b0;
      b1_q <= 1'b0;
      stb_q <= 1'b0;
    end
    else
    begin
      cclr_q <= home_rise;
      hstore_q <= home_rise;
      if (home_rise)
        home_q <= POS_NOW;
      if (st_q == S_RDY && req)
      begin
        b0_q <= grp_bits[0];
        b1_q <= grp_bits[1];
      end
      if (!repurpose)
      begin
        b0_q <= IN_POSITION;
        b1_q <= ZERO_SPEED;
        stb_q <= TORQUE_LIMIT;
      end
      else
        stb_q <= (st_d == S_RDY) || (st_d == S_LAST);
    end
  end

  wire [31:0] stat_w = 32'({st_q, opt_act_q, stage_q, ready_q, sonw_q, tmo_q});
  wire [31:0] rd_mux = (ADDRESS == A_CFG) ? 32'({opt_act_q, opt_cfg_q}) :
                       (ADDRESS == A_STAT) ? stat_w :
                       (ADDRESS == A_PCMD) ? pcmd_q :
                       (ADDRESS == A_HOME) ? home_q : 32'h0;

  // register slave: one wait cycle, then the answer
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      wait_q <= 1'b1;
      rdata_q <= '0;
      opt_cfg_q <= 1'b0;
      opt_act_q <= 1'b0;
    end
    else
    begin
      wait_q <= ~((READ | WRITE) & wait_q);
      if (WRITE && !wait_q && ADDRESS == A_CFG)
        opt_cfg_q <= WRITEDATA[CFG_OPT];
      // restart takes the option bit of the same write, as a power cycle would
      if (restart)
        opt_act_q <= WRITEDATA[CFG_OPT];
      if (READ && wait_q)
        rdata_q <= rd_mux;
    end
  end

  assign READDATA = rdata_q;
  assign WAITREQUEST = wait_q;
  assign DATA_BIT_LOW = b0_q;
  assign DATA_BIT_HIGH = b1_q;
  assign DATA_VALID_STROBE = stb_q;
  assign STAGE_ENABLE = stage_q;
  assign READY_OUT = ready_q;
  assign POS_CMD = pcmd_q;
  assign POS_CMD_LOAD = pload_q;
  assign COUNTER_CLEAR = cclr_q;
  assign HOME_STORE = hstore_q;
  assign HOME_POS = home_q;
  assign WARN_TIMEOUT = tmo_q;
  assign WARN_SERVO_ON = sonw_q;

  sequence grp_taken;
    st_q == S_RDY && req;
  endsequence
  sequence strobe_low_then;
    !stb_q ##1 1'b1;
  endsequence
  refuse_alarm_a: assert property (@(posedge CLK) disable iff (RESET) ALARM |-> !accept)
    else $error("entry accepted during alarm");
  refuse_ready_a: assert property (@(posedge CLK) disable iff (RESET) ready_q && st_q == S_IDLE |=> st_q != S_CALC)
    else $error("entry accepted while ready");
  stage_gate_a: assert property (@(posedge CLK) disable iff (RESET) !entered_q |=> !stage_q)
    else $error("stage on before transfer");
  group_drive_a: assert property (@(posedge CLK) disable iff (RESET) grp_taken ##1 repurpose |-> strobe_low_then)
    else $error("strobe not dropped after request");
  group_bits_a: assert property (@(posedge CLK) disable iff (RESET)
    grp_taken ##1 repurpose |-> b0_q == $past(grp_bits[0]) && b1_q == $past(grp_bits[1]))
    else $error("wrong group bits");
  abort_warn_a: assert property (@(posedge CLK) disable iff (RESET) abort_ev |=> tmo_q && st_q == S_IDLE)
    else $error("abort without warning");
  clear_warn_a: assert property (@(posedge CLK) disable iff (RESET) mode_rise && !abort_ev |=> !tmo_q)
    else $error("warning not cleared on mode rise");
  pins_restore_a: assert property (@(posedge CLK) disable iff (RESET) !repurpose |=> b0_q == $past(IN_POSITION))
    else $error("status pin not restored");
  latch_pos_a: assert property (@(posedge CLK) disable iff (RESET) accept |=> pload_q && pcmd_q == $past(POS_NOW))
    else $error("position not latched");
  home_set_a: assert property (@(posedge CLK) disable iff (RESET) home_rise |=> cclr_q && home_q == $past(POS_NOW))
    else $error("home not stored");
endmodule // abs_xfer

// ===== dv/plc_model.sv
// controller model that runs the position handshake from the far side
`timescale 1ns/10ps
module plc_model (
  // clock
  input wire logic clk,
  // pins from the servo block
  input wire logic strobe,
  input wire logic bit_lo,
  input wire logic bit_hi,
  // pins to the servo block
  output logic mode,
  output logic req,
  output logic servo_enable_in
);
  logic [37:0] got;
  int n;
  initial
  begin
    mode = 1'b0;
    req = 1'b0;
    servo_enable_in = 1'b0;
  end
  // every wait is bounded here, the block times out only in its ready, send and last states
  task automatic wait_lvl(input logic v, output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 200 && !ok; i++)
    begin
      @(posedge clk);
      ok = (strobe === v);
    end
  endtask
  task automatic mode_set(input logic v);
    @(posedge clk);
    mode <= v;
  endtask
  task automatic son_set(input logic v);
    @(posedge clk);
    servo_enable_in <= v;
  endtask
  // ngrp below 19 drops mode early on purpose
  task automatic run(input int ngrp, output logic ok);
    got = '0;
    n = 0;
    @(posedge clk);
    mode <= 1'b1;
    servo_enable_in <= 1'b1;
    wait_lvl(1'b1, ok);
    while (ok && n < ngrp)
    begin
      req <= 1'b1;
      wait_lvl(1'b0, ok);
      got[2*n +: 2] = {bit_hi, bit_lo};
      req <= 1'b0;
      wait_lvl(1'b1, ok);
      n++;
    end
    mode <= 1'b0;
  endtask
endmodule // plc_model

// ===== dv/tb_top.sv
// self-checking bench for the position handshake block
`timescale 1ns/10ps
module tb_top
  import abs_xfer_pkg::*;
;
  typedef struct packed {logic [31:0] pos; logic [5:0] sum;} row_t;
  row_t rows [4] = '{'{32'h0, 6'h0}, '{32'hfffffff6, 6'h2d}, '{32'h12345678, 6'h12}, '{32'hffffffff, 6'h30}};
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, q;
  logic waitrequest, mode, req, servo_enable_in, blo, bhi, stb, stage, rdy, cclr, hstore, warn_to, ok;
  logic pload, warn_son;
  logic home = 1'b0;
  logic fclr = 1'b0;
  logic fstop = 1'b1;
  logic alarm = 1'b0;
  logic [2:0] stat = 3'b011;
  logic [31:0] pos_now = 32'h0;
  logic [31:0] pos_cmd, home_pos;
  logic [1:0] hit;
  int num_errors = 0;
  int checks = 0;
  always #50 CLK = ~CLK;
  abs_xfer #(.OFF_CYC(20), .SON_CYC(50), .TMO_CYC(100)) dut (.CLK(CLK), .RESET(RESET), .ADDRESS(address),
    .READ(read), .WRITE(write), .WRITEDATA(writedata), .READDATA(readdata), .WAITREQUEST(waitrequest),
    .POSITION_TRANSFER_MODE(mode), .POSITION_GROUP_REQUEST(req), .HOME_SET_CMD(home),
    .SERVO_ENABLE_IN(servo_enable_in), .FAULT_CLEAR_IN(fclr), .FORCED_STOP_IN(fstop), .DATA_BIT_LOW(blo),
    .DATA_BIT_HIGH(bhi), .DATA_VALID_STROBE(stb), .POS_NOW(pos_now), .ALARM(alarm), .IN_POSITION(stat[0]),
    .ZERO_SPEED(stat[1]), .TORQUE_LIMIT(stat[2]), .STAGE_ENABLE(stage), .READY_OUT(rdy), .POS_CMD(pos_cmd),
    .POS_CMD_LOAD(pload), .COUNTER_CLEAR(cclr), .HOME_STORE(hstore), .HOME_POS(home_pos), .WARN_TIMEOUT(warn_to),
    .WARN_SERVO_ON(warn_son));
  plc_model plc (.clk(CLK), .strobe(stb), .bit_lo(blo), .bit_hi(bhi), .mode(mode), .req(req), .servo_enable_in(servo_enable_in));
  task automatic chk(input string nm, input logic [37:0] e, input logic [37:0] g);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int i;
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    i = 0;
    do
    begin
      @(posedge CLK);
      i++;
    end
    while (waitrequest !== 1'b0 && i < 50);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge CLK);
  endtask
  // son low well past the 20 cycle minimum off time
  task automatic rest();
    plc.son_set(1'b0);
    repeat (30) @(posedge CLK);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge CLK);
    num_errors++;
    conclude();
  end
  initial
  begin
    repeat (4) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    plc.run(19, ok);
    chk("no_option", 0, ok);
    chk("pins_idle", 3'b011, {stb, bhi, blo});
    rest();
    bus(1'b1, A_CFG, 32'h3);
    bus(1'b0, A_CFG, 32'h0);
    chk("cfg", 2'b11, q[1:0]);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", 0, q);
    $display("test config done");
    plc.son_set(1'b1);
    repeat (20) @(posedge CLK);
    chk("stage_off", 0, stage);
    rest();
    foreach (rows[k])
    begin
      pos_now <= rows[k].pos;
      plc.run(19, ok);
      chk("xfer", 1, ok);
      chk("data", {rows[k].sum, rows[k].pos}, plc.got);
      repeat (8) @(posedge CLK);
      chk("ready", 1, rdy);
      chk("stage_on", 1, stage);
      chk("pins", 3'b011, {stb, bhi, blo});
      chk("pos_cmd", rows[k].pos, pos_cmd);
      bus(1'b0, A_PCMD, 32'h0);
      chk("pos_cmd_reg", rows[k].pos, q);
      if (k < 3)
        rest();
      $display("test row %0d done", k);
    end
    plc.run(19, ok);
    chk("refuse_ready", 0, ok);
    rest();
    plc.run(5, ok);
    repeat (8) @(posedge CLK);
    chk("abort_warn", 1, warn_to);
    chk("abort_rdy", 0, rdy);
    rest();
    plc.run(19, ok);
    chk("warn_clear", 0, warn_to);
    rest();
    $display("test abort done");
    alarm <= 1'b1;
    plc.run(19, ok);
    chk("alarm_refuse", 0, ok);
    chk("alarm_stage", 0, stage);
    alarm <= 1'b0;
    rest();
    $display("test alarm done");
    plc.mode_set(1'b1);
    hit = 2'b00;
    for (int i = 0; i < 70; i++)
    begin
      @(posedge CLK);
      hit[0] = hit[0] | (pload === 1'b1);
    end
    chk("pload", 1, hit[0]);
    chk("son_warn", 1, warn_son);
    plc.son_set(1'b1);
    repeat (8) @(posedge CLK);
    chk("son_warn_clear", 0, warn_son);
    chk("son_warn_xfer", 1, stb);
    chk("son_warn_to", 0, warn_to);
    plc.son_set(1'b0);
    repeat (8) @(posedge CLK);
    chk("son_drop_warn", 1, warn_to);
    plc.mode_set(1'b0);
    rest();
    $display("test servo-on done");
    home <= 1'b1;
    hit = 2'b00;
    for (int i = 0; i < 20; i++)
    begin
      @(posedge CLK);
      hit = hit | {hstore === 1'b1, cclr === 1'b1};
    end
    chk("home_pulse", 2'b11, hit);
    chk("home_pos", pos_now, home_pos);
    home <= 1'b0;
    $display("test home done");
    conclude();
  end
endmodule // tb_top
